// ==== ks_defines.vh ====
`ifndef KS_DEFINES_VH
`define KS_DEFINES_VH
// Register offsets on the host register port.
`define KS_OFS_CFG 8'h01
`define KS_OFS_STAT 8'h02
`define KS_OFS_LOCK 8'h03
`define KS_OFS_EVENT 8'h04
`define KS_OFS_COUNT 8'h05
`define KS_OFS_TIMERS 8'h0E
`define KS_OFS_UNLK1 8'h0F
`define KS_OFS_UNLK2 8'h10
`define KS_OFS_SELR 8'h1D
`define KS_OFS_SELC 8'h1E
`define KS_OFS_SELH 8'h1F
// Bit positions inside the configuration register.
`define KS_CFG_KEY_EVENT_IRQ_ENABLE 0
`define KS_CFG_LCK_IEN 2
`define KS_CFG_SPILL_IEN 3
`define KS_CFG_INT_CFG 4
`define KS_CFG_POLICY 5
// Bit positions inside the interrupt status register.
`define KS_ST_KEY 0
`define KS_ST_LOCK 2
`define KS_ST_SPILL 3
`define KS_ST_SALUTE 4
// Lock register: state bit and armed bit.
`define KS_LOCK_BIT 6
`define KS_ARMED_BIT 5
// Reset value of every host register.
`define KS_REG_RESET 8'h00
// Matrix geometry and queue depth.
`define KS_COLS 10
`define KS_KEYS 80
`define KS_QDEPTH 4'hA
`define KS_LAST_KEY 7'h4F
`define KS_LAST_COL 4'h9
// Key indices of the three-key salute (codes 1, 11 and 21).
`define KS_SALUTE_A 0
`define KS_SALUTE_B 10
`define KS_SALUTE_C 20
// Cycles a driven column settles before its rows are sampled.
`define KS_SETTLE 4'h4
// Clock rate and timing figures.
`define KS_CLK_MHZ 25
`define KS_GAP_US 50
`define KS_GAP_CYC (`KS_GAP_US * `KS_CLK_MHZ)
`define KS_SEC_CYC 25000000
`endif

// ==== ks_matrix.sv ====
`timescale 1ns/10ps
`default_nettype none
module ks_matrix (
   input wire logic clk,
   input wire logic [79:0] keys,
   input wire logic [9:0] col_oe,
   input wire logic [9:0] col_out,
   input wire logic [7:0] pull_en,
   output logic [7:0] row_in
);
   logic flt = 1'b0; // Changing level of a row nobody pulls up.
   logic lvl; // Level of the row being resolved.
   integer r, c, g, h;
   // A floating row shows no steady value.
   always @(posedge clk) flt <= ~flt;
   // Each row is low when a closed key, or a path of three closed keys, reaches a driven column.
   always @* begin
      for (r = 0; r < 8; r = r + 1) begin
         lvl = 1'b1;
         for (c = 0; c < 10; c = c + 1) begin
            if (col_oe[c] && !col_out[c]) begin
               if (keys[r*10+c]) lvl = 1'b0;
               for (g = 0; g < 8; g = g + 1) begin
                  for (h = 0; h < 10; h = h + 1) begin
                     if (keys[r*10+h] && keys[g*10+h] && keys[g*10+c]) lvl = 1'b0;
                  end
               end
            end
         end
         row_in[r] = (pull_en[r] || !lvl) ? lvl : flt;
      end
   end
endmodule // ks_matrix
`default_nettype wire

// ==== ks_scan.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ks_defines.vh"

// Functional notes
// [R1] Overflow flag only once an event is lost.
// [R2] Idle: rows pulled-up inputs, columns driven low.
// [R3] A low row starts the scan.
// [R4] Scan drives one column low at a time.
// [R5] Internal pull-ups enabled on matrix rows.
// [R6] Key code is ten times row plus column plus one.
// [R7] Codes 1, 11, 21 together set salute flag.
// [R8] Select registers assign pins to the matrix.
// [R9] Clear with pending events: release 50 us, reassert.
// [R10] Two registers hold the unlock key codes.
// [R11] Second unlock key within interval unlocks.
// [R12] Lock timer register holds interval and mask time.
// [R13] No ghost suppression; phantom keys are reported.
// [R14] Overflow interrupt needs policy and enable bits.
// [R15] Full queue: push out oldest or drop new.
// [R16] Status flags clear by writing one; here the key flag stays set while events are pending and the gap option is off.
// [R17] Each press and release queues one event.
// [R18] Key event sets flag when enabled.
module ks_scan #(
   parameter SEC_CYCLES = `KS_SEC_CYC
) (
   input wire CLK,
   input wire RST,
   input wire [7:0] ROW_IN,
   output reg [9:0] COL_OUT,
   output reg [9:0] COL_OE,
   output reg [7:0] ROW_PULLUP,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   output reg INT_N
);
   // Scanner states.
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_SCAN = 2'h1;
   localparam [1:0] ST_CMP = 2'h2;
   // Full-width copies, cut on purpose to the counter widths below.
   localparam [31:0] SEC_FULL = SEC_CYCLES - 1;
   localparam [31:0] GAP_FULL = `KS_GAP_CYC;
   localparam [24:0] SEC_LAST = SEC_FULL[24:0];
   localparam [10:0] GAP_CYC = GAP_FULL[10:0];

   // Host registers.
   reg [7:0] cfg;
   reg [7:0] timers;
   reg [7:0] unlk1;
   reg [7:0] unlk2;
   reg [7:0] selr;
   reg [7:0] selc;
   reg [7:0] selh;
   reg [7:0] stat;
   reg locked;
   reg armed;
   reg [2:0] lock_sec;
   reg [24:0] sec_cnt;
   // Row synchroniser; only row_s2 feeds logic.
   reg [7:0] row_s1;
   reg [7:0] row_s2;
   // Scanner state.
   reg [1:0] state;
   reg [3:0] col_idx;
   reg [3:0] settle;
   reg [6:0] key_idx;
   reg [79:0] key_now;
   reg [79:0] key_old;
   reg salute_d;
   // Two-entry buffer between scanner and queue.
   reg [7:0] b0;
   reg [7:0] b1;
   reg [1:0] bcnt;
   // Event queue.
   reg [7:0] q [0:9];
   reg [3:0] head;
   reg [3:0] qcnt;
   // Interrupt release gap.
   reg [10:0] gap;

   // Decoded host accesses.
   wire wr_cfg = WR && (ADDR == `KS_OFS_CFG);
   wire wr_stat = WR && (ADDR == `KS_OFS_STAT);
   wire rd_event = RD && (ADDR == `KS_OFS_EVENT);
   wire [9:0] col_sel = {selh[1:0], selc};
   wire [7:0] rows_low = selr & ~row_s2;
   wire sample = (state == ST_SCAN) && (settle == `KS_SETTLE);
   wire diff = key_now[key_idx] != key_old[key_idx];
   wire [6:0] code = key_idx + 7'h01;
   wire in_valid = (state == ST_CMP) && diff;
   wire in_ready = (bcnt != 2'h2);
   wire push_b = in_valid && in_ready;
   wire step = (state == ST_CMP) && (!diff || in_ready);
   // The queue takes no word while the host pops it.
   wire out_ready = !rd_event;
   wire pop_b = (bcnt != 2'h0) && out_ready;
   wire ev_press = b0[7];
   wire [6:0] ev_code = b0[6:0];
   wire unlock_hit = pop_b && ev_press && locked && armed && (ev_code == unlk2[6:0]);
   wire arm_hit = pop_b && ev_press && locked && !unlock_hit && (ev_code == unlk1[6:0]);
   wire enq = pop_b && !locked;
   wire full_hit = enq && (qcnt == `KS_QDEPTH);
   wire sec_tick = (sec_cnt == SEC_LAST);
   wire [4:0] tsum = head + qcnt;
   wire [3:0] tail = (tsum >= 5'h0A) ? (tsum[3:0] - 4'hA) : tsum[3:0];
   wire [3:0] head_inc = (head == 4'h9) ? 4'h0 : (head + 4'h1);
   wire pop_q = rd_event && (qcnt != 4'h0);
   wire salute = key_old[`KS_SALUTE_A] & key_old[`KS_SALUTE_B] & key_old[`KS_SALUTE_C];
   wire pend_clr = wr_stat && WDATA[`KS_ST_KEY] && (qcnt != 4'h0);
   wire gap_start = pend_clr && cfg[`KS_CFG_INT_CFG];
   wire gap_done = (gap == 11'h001);
   reg [7:0] set;
   reg [7:0] clr;

   // Flag sets and clears; a set in the clear cycle wins.
   always @* begin
      set = 8'h00;
      clr = wr_stat ? WDATA : 8'h00; // [R16]
      set[`KS_ST_KEY] = (enq && cfg[`KS_CFG_KEY_EVENT_IRQ_ENABLE]) || (gap_done && qcnt != 4'h0); // [R18] [R9]
      if (pend_clr && !cfg[`KS_CFG_INT_CFG]) begin
         clr[`KS_ST_KEY] = 1'b0; // [R9]
      end
      set[`KS_ST_LOCK] = arm_hit && cfg[`KS_CFG_LCK_IEN];
      set[`KS_ST_SPILL] = full_hit && cfg[`KS_CFG_POLICY] && cfg[`KS_CFG_SPILL_IEN]; // [R14] [R1]
      set[`KS_ST_SALUTE] = salute && !salute_d; // [R7]
   end

   // Host register writes and status flags.
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg <= `KS_REG_RESET;
         timers <= `KS_REG_RESET;
         unlk1 <= `KS_REG_RESET;
         unlk2 <= `KS_REG_RESET;
         selr <= `KS_REG_RESET;
         selc <= `KS_REG_RESET;
         selh <= `KS_REG_RESET;
         stat <= `KS_REG_RESET;
         salute_d <= 1'b0;
      end else begin
         salute_d <= salute;
         stat <= (stat & ~clr) | set; // [R16]
         if (wr_cfg) begin
            cfg <= WDATA;
         end
         if (WR && ADDR == `KS_OFS_TIMERS) begin
            timers <= WDATA; // [R12]
         end
         if (WR && ADDR == `KS_OFS_UNLK1) begin
            unlk1 <= WDATA; // [R10]
         end
         if (WR && ADDR == `KS_OFS_UNLK2) begin
            unlk2 <= WDATA; // [R10]
         end
         if (WR && ADDR == `KS_OFS_SELR) begin
            selr <= WDATA; // [R8]
         end
         if (WR && ADDR == `KS_OFS_SELC) begin
            selc <= WDATA; // [R8]
         end
         if (WR && ADDR == `KS_OFS_SELH) begin
            selh <= WDATA; // [R8]
         end
      end
   end

   // Interrupt output, released while the gap counter runs.
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         gap <= 11'h000;
         INT_N <= 1'b1;
      end else begin
         if (gap_start) begin
            gap <= GAP_CYC; // [R9]
         end else if (gap != 11'h000) begin
            gap <= gap - 11'h001;
         end
         INT_N <= (gap != 11'h000) || gap_start || (stat == 8'h00); // [R9]
      end
   end

   // Keypad lock and the two-key unlock sequence.
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         locked <= 1'b0;
         armed <= 1'b0;
         lock_sec <= 3'h0;
         sec_cnt <= 25'h0000000;
      end else begin
         sec_cnt <= (arm_hit || sec_tick) ? 25'h0000000 : (sec_cnt + 25'h0000001);
         if (WR && ADDR == `KS_OFS_LOCK) begin
            locked <= WDATA[`KS_LOCK_BIT];
            armed <= 1'b0;
         end else if (unlock_hit) begin
            locked <= 1'b0; // [R11]
            armed <= 1'b0;
         end else if (arm_hit) begin
            armed <= 1'b1; // [R11]
            lock_sec <= timers[2:0]; // [R12]
         end else if (armed && sec_tick) begin
            lock_sec <= lock_sec - 3'h1;
            if (lock_sec <= 3'h1) begin
               armed <= 1'b0; // [R11]
            end
         end
      end
   end

   // Row synchroniser and pin drive; unselected pins are left alone.
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         row_s1 <= 8'h00;
         row_s2 <= 8'h00;
         ROW_PULLUP <= 8'h00;
         COL_OUT <= 10'h000;
      end else begin
         row_s1 <= ROW_IN;
         row_s2 <= row_s1;
         ROW_PULLUP <= selr; // [R5] [R2]
         COL_OUT <= 10'h000;
      end
   end

   // Scan sequencer: idle watch, column sweep, compare pass.
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         state <= ST_IDLE;
         col_idx <= 4'h0;
         settle <= 4'h0;
         key_idx <= 7'h00;
         COL_OE <= 10'h000;
      end else begin
         case (state)
            ST_IDLE: begin
               COL_OE <= col_sel; // [R2]
               if (rows_low != 8'h00) begin
                  state <= ST_SCAN; // [R3]
                  col_idx <= 4'h0;
                  settle <= 4'h0;
                  COL_OE <= col_sel & 10'h001; // [R4]
               end
            end
            ST_SCAN: begin
               settle <= settle + 4'h1;
               if (sample) begin
                  settle <= 4'h0;
                  if (col_idx == `KS_LAST_COL) begin
                     state <= ST_CMP;
                     key_idx <= 7'h00;
                     COL_OE <= col_sel;
                  end else begin
                     col_idx <= col_idx + 4'h1;
                     COL_OE <= col_sel & (10'h002 << col_idx); // [R4]
                  end
               end
            end
            ST_CMP: begin
               if (step) begin
                  key_idx <= key_idx + 7'h01;
                  if (key_idx == `KS_LAST_KEY) begin
                     // Keep sweeping while any key is down to catch releases.
                     if (key_now != 80'h0) begin
                        state <= ST_SCAN;
                        col_idx <= 4'h0;
                        COL_OE <= col_sel & 10'h001;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Per-key sampling; every selected low row on a selected driven column counts.
   genvar k;
   generate
      for (k = 0; k < `KS_KEYS; k = k + 1) begin : g_key
         always @(posedge CLK or posedge RST) begin
            if (RST) begin
               key_now[k] <= 1'b0;
               key_old[k] <= 1'b0;
            end else begin
               if (sample && col_idx == (k % `KS_COLS)) begin
                  key_now[k] <= rows_low[k / `KS_COLS] & col_sel[k % `KS_COLS]; // [R4] [R13]
               end
               if (push_b && key_idx == k) begin
                  key_old[k] <= key_now[k]; // [R17]
               end
            end
         end
      end
   endgenerate

   // Two-entry buffer; when full it stalls the compare pass.
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         b0 <= 8'h00;
         b1 <= 8'h00;
         bcnt <= 2'h0;
      end else begin
         case ({push_b, pop_b})
            2'b10: begin
               if (bcnt == 2'h0) begin
                  b0 <= {key_now[key_idx], code}; // [R6] [R17]
               end else begin
                  b1 <= {key_now[key_idx], code}; // [R6] [R17]
               end
               bcnt <= bcnt + 2'h1;
            end
            2'b01: begin
               b0 <= b1;
               bcnt <= bcnt - 2'h1;
            end
            2'b11: begin
               if (bcnt == 2'h1) begin
                  b0 <= {key_now[key_idx], code}; // [R6]
               end else begin
                  b0 <= b1;
                  b1 <= {key_now[key_idx], code}; // [R6]
               end
            end
            default: begin
               bcnt <= bcnt;
            end
         endcase
      end
   end

   // Event queue with the overflow policy.
   integer i;
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         head <= 4'h0;
         qcnt <= 4'h0;
         for (i = 0; i < 10; i = i + 1) begin
            q[i] <= 8'h00;
         end
      end else begin
         if (pop_q) begin
            head <= head_inc;
            qcnt <= qcnt - 4'h1;
         end else if (enq) begin
            if (qcnt != `KS_QDEPTH) begin
               q[tail] <= b0; // [R17]
               qcnt <= qcnt + 4'h1;
            end else if (cfg[`KS_CFG_POLICY]) begin
               q[head] <= b0; // [R15]
               head <= head_inc; // [R15]
            end
         end
      end
   end

   // Registered read data; unmapped offsets read zero.
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            `KS_OFS_CFG: RDATA <= cfg;
            `KS_OFS_STAT: RDATA <= stat;
            `KS_OFS_LOCK: RDATA <= {1'b0, locked, armed, 5'h00};
            `KS_OFS_EVENT: RDATA <= (qcnt != 4'h0) ? q[head] : 8'h00;
            `KS_OFS_COUNT: RDATA <= {4'h0, qcnt};
            `KS_OFS_TIMERS: RDATA <= timers;
            `KS_OFS_UNLK1: RDATA <= unlk1;
            `KS_OFS_UNLK2: RDATA <= unlk2;
            `KS_OFS_SELR: RDATA <= selr;
            `KS_OFS_SELC: RDATA <= selc;
            `KS_OFS_SELH: RDATA <= selh;
            default: RDATA <= 8'h00;
         endcase
      end
   end
endmodule // ks_scan
`default_nettype wire

// ==== ks_scan_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module ks_scan_props (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] ROW_IN,
   input wire logic [9:0] COL_OUT,
   input wire logic [9:0] COL_OE,
   input wire logic [7:0] ROW_PULLUP,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic INT_N
);
   logic [7:0] sel_r; // Shadow of the row select register.
   logic [9:0] sel_c; // Shadow of both column select registers.
   logic int_cfg; // Shadow of the interrupt gap option.
   logic [7:0] quiet; // Cycles with all selected rows high.
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // Track host writes so pin checks know the selection.
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         sel_r <= 8'h00;
         sel_c <= 10'h000;
         int_cfg <= 1'b0;
      end else if (WR) begin
         if (ADDR == 8'h1D) sel_r <= WDATA;
         if (ADDR == 8'h1E) sel_c[7:0] <= WDATA;
         if (ADDR == 8'h1F) sel_c[9:8] <= WDATA[1:0];
         if (ADDR == 8'h01) int_cfg <= WDATA[4];
      end
   end
   // Count quiet cycles; a write restarts the count.
   always @(posedge CLK or posedge RST) begin
      if (RST) quiet <= 8'h00;
      else if (WR || (ROW_IN | ~sel_r) != 8'hFF) quiet <= 8'h00;
      else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
   end
   sequence s_row_falls;
      sel_c != 10'h000 && COL_OE == sel_c && $rose((ROW_IN | ~sel_r) != 8'hFF);
   endsequence
   sequence s_clear_key;
      WR && ADDR == 8'h02 && WDATA == 8'h01 && int_cfg && !INT_N;
   endsequence
   sequence s_released;
      INT_N [*8];
   endsequence
   a_cols_drive_low: assert property (COL_OUT == 10'h000)
      else $error("column output value not low");
   a_idle_cols: assert property (quiet > 8'd200 |-> COL_OE == sel_c)
      else $error("idle columns differ from selection");
   // Pin enables follow a select write one clock later.
   a_pullup_select: assert property (ROW_PULLUP == $past(sel_r))
      else $error("row pull-ups differ from selection");
   a_cols_selected: assert property ((COL_OE & ~$past(sel_c)) == 10'h000)
      else $error("unselected column driven");
   a_column_dwell: assert property (
      ($changed(COL_OE) && $onehot(COL_OE) && !$onehot(sel_c)) |=> $stable(COL_OE) [*4])
      else $error("scan column left too early");
   // A row may fall during a compare pass, which runs to its end before the sweep.
   a_scan_start: assert property (s_row_falls |-> ##[1:150] $onehot(COL_OE))
      else $error("row activity did not start a scan");
   a_gap_release: assert property (s_clear_key |-> ##3 s_released)
      else $error("interrupt not released after clear");
   a_unmapped_read: assert property (RD && ADDR == 8'h20 |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!RD |=> $stable(RDATA))
      else $error("read data changed without a read");
endmodule // ks_scan_props
bind ks_scan ks_scan_props ks_scan_props_i (.CLK(CLK), .RST(RST), .ROW_IN(ROW_IN),
   .COL_OUT(COL_OUT), .COL_OE(COL_OE), .ROW_PULLUP(ROW_PULLUP), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .INT_N(INT_N));
`default_nettype wire

// ==== ks_scan_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module ks_scan_test;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [79:0] keys = 80'h0; // Closed switches, bit 10*row+col.
   wire [7:0] ROW_IN;
   wire [9:0] COL_OUT;
   wire [9:0] COL_OE;
   wire [7:0] ROW_PULLUP;
   wire [7:0] RDATA;
   wire INT_N;
   int bad_count = 0;
   int comparisons = 0;
   int i;
   logic [7:0] d; // Last value read.
   logic [7:0] ra [6] = '{8'h1D, 8'h1E, 8'h1F, 8'h0E, 8'h0F, 8'h10};
   logic [7:0] rv [6] = '{8'h0F, 8'h07, 8'h00, 8'h52, 8'h21, 8'h01};
   logic [7:0] ev [4] = '{8'h81, 8'h82, 8'h8B, 8'h8C};
   always #20 CLK = ~CLK;
   ks_scan #(.SEC_CYCLES(200)) ks_scan_i (.CLK(CLK), .RST(RST), .ROW_IN(ROW_IN),
      .COL_OUT(COL_OUT), .COL_OE(COL_OE), .ROW_PULLUP(ROW_PULLUP), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .INT_N(INT_N));
   ks_matrix ks_matrix_i (.clk(CLK), .keys(keys), .col_oe(COL_OE), .col_out(COL_OUT),
      .pull_en(ROW_PULLUP), .row_in(ROW_IN));
   // Print the counts and the verdict, then stop.
   task close_out;
      $display("Counts: %0d mismatches, %0d comparisons", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Compare one value and count it.
   task chk(input string n, input logic [9:0] e, input logic [9:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Wait some cycles, then let the edge settle.
   task cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   // Read until the masked value matches, within a bound.
   task poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
      int k;
      for (k = 0; k < 3000; k++) begin
         rd(a);
         if ((d & m) === v) return;
      end
      bad_count++;
      $display("MISMATCH poll %h expected %h seen %h", a, v, d & m);
      close_out();
   endtask
   // Wait for n queued events and pop them all.
   task drain(input logic [7:0] n);
      poll(8'h05, 8'hFF, n);
      repeat (n) rd(8'h04);
   endtask
   initial begin
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      chk("int_n", 10'h001, {9'h0, INT_N});
      for (i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk("reset", 10'h000, {2'h0, d});
      end
      for (i = 0; i < 6; i++) wr(ra[i], rv[i]);
      wr(8'h20, 8'hFF);
      for (i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk("reg", {2'h0, rv[i]}, {2'h0, d});
      end
      rd(8'h20);
      chk("unmapped", 10'h000, {2'h0, d});
      // Rows float until their pull-ups come on, so the select write starts one empty scan.
      cyc(150);
      chk("pullup", 10'h00F, {2'h0, ROW_PULLUP});
      chk("idle_cols", 10'h007, COL_OE);
      wr(8'h01, 8'h01);
      keys <= 80'h1 << 32;
      poll(8'h05, 8'hFF, 8'h01);
      chk("int_n", 10'h000, {9'h0, INT_N});
      rd(8'h04);
      chk("event", 10'h0A1, {2'h0, d});
      keys <= 80'h0;
      poll(8'h05, 8'hFF, 8'h01);
      rd(8'h04);
      chk("event", 10'h021, {2'h0, d});
      wr(8'h02, 8'hFF);
      keys <= 80'h403;
      poll(8'h05, 8'hFF, 8'h04);
      for (i = 0; i < 4; i++) begin
         rd(8'h04);
         chk("ghost", {2'h0, ev[i]}, {2'h0, d});
      end
      keys <= 80'h0;
      drain(8'h04);
      wr(8'h02, 8'hFF);
      keys <= 80'h100401;
      poll(8'h05, 8'hFF, 8'h03);
      rd(8'h02);
      chk("salute", 10'h010, {2'h0, d & 8'h10});
      wr(8'h02, 8'h10);
      rd(8'h02);
      chk("salute", 10'h000, {2'h0, d & 8'h10});
      keys <= 80'h0;
      drain(8'h06);
      wr(8'h02, 8'hFF);
      wr(8'h01, 8'h11);
      keys <= 80'h1;
      poll(8'h05, 8'hFF, 8'h01);
      wr(8'h02, 8'h01);
      cyc(3);
      chk("gap", 10'h001, {9'h0, INT_N});
      cyc(1200);
      chk("gap", 10'h001, {9'h0, INT_N});
      for (i = 0; i < 200 && INT_N !== 1'b0; i++) cyc(1);
      chk("reassert", 10'h000, {9'h0, INT_N});
      keys <= 80'h0;
      drain(8'h02);
      wr(8'h02, 8'hFF);
      wr(8'h01, 8'h28);
      for (i = 0; i < 5; i++) begin
         keys <= 80'h1;
         poll(8'h05, 8'hFF, 8'(2 * i + 1));
         keys <= 80'h0;
         poll(8'h05, 8'hFF, 8'(2 * i + 2));
      end
      rd(8'h02);
      chk("spill", 10'h000, {2'h0, d & 8'h08});
      keys <= 80'h1;
      poll(8'h02, 8'h08, 8'h08);
      rd(8'h05);
      chk("count", 10'h00A, {2'h0, d});
      rd(8'h04);
      chk("oldest", 10'h001, {2'h0, d});
      keys <= 80'h0;
      drain(8'h0A);
      // Lock with the lock flag enabled, so arming is seen in the status too.
      wr(8'h01, 8'h04);
      wr(8'h03, 8'h40);
      keys <= 80'h1 << 32;
      poll(8'h03, 8'h20, 8'h20);
      rd(8'h02);
      chk("lock_flag", 10'h004, {2'h0, d & 8'h04});
      keys <= (80'h1 << 32) | 80'h1;
      poll(8'h03, 8'h40, 8'h00);
      close_out();
   end
endmodule // ks_scan_test
`default_nettype wire
